// ==== logic/isu_pkg.sv ====
// constants and operation codes for the integer shift and subtract slice
// assumes a single core clock and a synchronous active-low core reset
package isu_pkg;
  // data word width
  localparam int WORD_W = 32;
  // width of a shift count
  localparam int SHAMT_W = 5;
  // sign bit position of a word
  localparam int SIGN_POS = 31;
  // reset value of the result register
  localparam logic [WORD_W-1:0] RESULT_RST = 32'h0;
  // reset value of the write enable and overflow flags
  localparam logic FLAG_RST = 1'b0;
  // latency from accept to result in core cycles
  localparam int LATENCY = 1;
  // operation select
  typedef enum logic [2:0] {
    ISU_SRA_REG,
    ISU_SRL_IMM,
    ISU_SRL_REG,
    ISU_SUB_TRAP,
    ISU_SUB_MOD
  } isu_op_e;
endpackage : isu_pkg

// ==== logic/isu_int_shift_subtract_unit.sv ====
// integer execution slice: three right shifts and two subtracts
// assumes operands are synchronous to clk and valid while opValid is high
// assumes the register file and exception logic act on the registered outputs
`timescale 1ns/1ps
`default_nettype none
module isu_int_shift_subtract_unit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic opValid,
  input wire isu_pkg::isu_op_e opSel,
  input wire logic [isu_pkg::WORD_W-1:0] firstSource,
  input wire logic [isu_pkg::WORD_W-1:0] secondSource,
  input wire logic [isu_pkg::SHAMT_W-1:0] shiftAmountField,
  output logic [isu_pkg::WORD_W-1:0] result,
  output logic destWrite,
  output logic overflow
);
  import isu_pkg::*;

  // registered outputs and their next values
  logic [WORD_W-1:0] result_q, result_d;
  logic destWrite_q, destWrite_d;
  logic overflow_q, overflow_d;
  // shift count for the register forms, taken from the count operand
  logic [SHAMT_W-1:0] shiftCount;
  // sign-extended 33-bit difference
  logic [WORD_W:0] diffWide;

  // next-value computation for all operations
  always_comb
  begin
    result_d = RESULT_RST;
    destWrite_d = FLAG_RST;
    overflow_d = FLAG_RST;
    // register forms use only the low five bits of the count operand
    shiftCount = firstSource[SHAMT_W-1:0];
    diffWide = {firstSource[SIGN_POS], firstSource} - {secondSource[SIGN_POS], secondSource};
    if (opValid)
    begin
      case (opSel)
        // arithmetic shift, sign copied into vacated bits
        ISU_SRA_REG:
        begin
          result_d = WORD_W'($signed(secondSource) >>> shiftCount);
          destWrite_d = 1'b1;
        end
        // logical shift by instruction field, not register
        ISU_SRL_IMM:
        begin
          result_d = secondSource >> shiftAmountField;
          destWrite_d = 1'b1;
        end
        // logical shift by register count
        ISU_SRL_REG:
        begin
          result_d = secondSource >> shiftCount;
          destWrite_d = 1'b1;
        end
        // trapping subtract: suppress write on overflow
        ISU_SUB_TRAP:
        begin
          result_d = diffWide[WORD_W-1:0];
          overflow_d = diffWide[WORD_W] != diffWide[SIGN_POS];
          destWrite_d = !overflow_d;
        end
        // modulo subtract: always write, never flag
        ISU_SUB_MOD:
        begin
          result_d = diffWide[WORD_W-1:0];
          destWrite_d = 1'b1;
        end
        // unknown select gives no write
        default:
        begin
          result_d = RESULT_RST;
        end
      endcase
    end
  end

  // output registers, cleared by reset, frozen while clkEn is low
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      result_q <= RESULT_RST;
      destWrite_q <= FLAG_RST;
      overflow_q <= FLAG_RST;
    end
    else if (clkEn)
    begin
      result_q <= result_d;
      destWrite_q <= destWrite_d;
      overflow_q <= overflow_d;
    end
  end

  assign result = result_q;
  assign destWrite = destWrite_q;
  assign overflow = overflow_q;

  // assertion helpers: immediate shift input taken in the current enabled cycle
  logic takenSrl;
  assign takenSrl = clkEn && opValid && opSel == ISU_SRL_IMM;

  // the checks below look one edge after an enabled accept; the registered
  // outputs then hold whatever the accept produced, even if the following
  // edge is stalled, so $past of the operands is the accepted value
  // reset is left out of most checks: the outputs are simply zero then

  // accepted requests of each kind but the immediate shift (that one is takenSrl), the first step of the checks below
  sequence takeSra;
    clkEn && opValid && opSel == ISU_SRA_REG;
  endsequence
  sequence takeSrlReg;
    clkEn && opValid && opSel == ISU_SRL_REG;
  endsequence
  sequence takeSubTrap;
    clkEn && opValid && opSel == ISU_SUB_TRAP;
  endsequence
  sequence takeSubMod;
    clkEn && opValid && opSel == ISU_SUB_MOD;
  endsequence

  // a sign-set arithmetic shift result keeps bit 31 set
  sra_sign_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSra ##0 secondSource[SIGN_POS] |=> result[SIGN_POS])
    else $error("arithmetic shift lost sign");
  // a sign-clear arithmetic shift result keeps bit 31 clear
  sra_pos_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSra ##0 !secondSource[SIGN_POS] |=> !result[SIGN_POS])
    else $error("arithmetic shift set sign");
  // a zero low count passes the word through, whatever the upper bits
  sra_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSra ##0 firstSource[SHAMT_W-1:0] == 5'h0 |=> result == $past(secondSource))
    else $error("arithmetic shift by zero wrong");
  // variable count ignores upper count bits
  var_count_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSrlReg |=> result == ($past(secondSource) >> $past(firstSource[SHAMT_W-1:0])))
    else $error("variable shift count wrong");
  // register logical shift by nonzero count clears the top bit
  srl_reg_top_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSrlReg ##0 firstSource[SHAMT_W-1:0] != 5'h0 |=> !result[SIGN_POS])
    else $error("register shift not zero filled");
  // immediate shift uses the field
  imm_shift_a: assert property (@(posedge clk) disable iff (!resetn)
    takenSrl |=> result == ($past(secondSource) >> $past(shiftAmountField)))
    else $error("immediate shift wrong");
  // immediate shift by zero leaves the word unchanged
  imm_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    takenSrl && shiftAmountField == 5'h0 |=> result == $past(secondSource))
    else $error("immediate shift by zero wrong");
  // immediate logical shift by nonzero count clears the top bit
  zero_fill_a: assert property (@(posedge clk) disable iff (!resetn)
    takenSrl && shiftAmountField != 5'h0 |=> !result[SIGN_POS])
    else $error("logical shift not zero filled");
  // register shifts never flag overflow and always write
  shift_notrap_a: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && opValid && (opSel == ISU_SRA_REG || opSel == ISU_SRL_REG)
    |=> destWrite && !overflow)
    else $error("shift trapped");
  // the immediate shift also always writes without a flag
  imm_write_a: assert property (@(posedge clk) disable iff (!resetn)
    takenSrl |=> destWrite && !overflow)
    else $error("immediate shift trapped");
  // trapping subtract without overflow writes the difference
  sub_write_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSubTrap ##0 !overflow_d
    |=> destWrite && result == $past(firstSource) - $past(secondSource))
    else $error("subtract result wrong");
  // operands of equal sign can never overflow
  same_sign_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSubTrap ##0 firstSource[SIGN_POS] == secondSource[SIGN_POS]
    |=> destWrite && !overflow)
    else $error("overflow on equal signs");
  // overflow blocks the write
  sub_ovf_a: assert property (@(posedge clk) disable iff (!resetn)
    overflow |-> !destWrite)
    else $error("overflow with write");
  // overflow on most negative minus one
  ovf_detect_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSubTrap ##0 firstSource == 32'h80000000 && secondSource == 32'h1
    |=> overflow && !destWrite)
    else $error("overflow missed");
  // overflow on most positive minus minus one
  ovf_pos_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSubTrap ##0 firstSource == 32'h7fffffff && secondSource == 32'hffffffff
    |=> overflow && !destWrite)
    else $error("positive overflow missed");
  // modulo subtract always writes without overflow
  sub_mod_a: assert property (@(posedge clk) disable iff (!resetn)
    takeSubMod
    |=> destWrite && !overflow && result == $past(firstSource) - $past(secondSource))
    else $error("modulo subtract wrong");
  // only the trapping subtract may raise the flag
  only_trap_a: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && opValid && opSel != ISU_SUB_TRAP |=> !overflow)
    else $error("flag from non-trapping op");
  // no write without an accepted operation
  idle_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && !opValid |=> !destWrite && !overflow)
    else $error("spurious write");
  // an undefined select gives a zero result and no write
  bad_select_a: assert property (@(posedge clk) disable iff (!resetn)
    clkEn && opValid && opSel > ISU_SUB_MOD
    |=> result == RESULT_RST && !destWrite && !overflow)
    else $error("undefined select acted");
  // a stalled edge leaves every output as it was
  hold_frozen_a: assert property (@(posedge clk) disable iff (!resetn)
    !clkEn |=> $stable(result) && $stable(destWrite) && $stable(overflow))
    else $error("outputs moved while stalled");
  // reset clears every output at the next edge
  reset_clear_a: assert property (@(posedge clk)
    !resetn |=> result == RESULT_RST && destWrite == FLAG_RST && overflow == FLAG_RST)
    else $error("outputs not cleared by reset");
endmodule : isu_int_shift_subtract_unit
`default_nettype wire

// ==== sim/isu_stall_model.sv ====
// issue-stage model: stalls the slice through its clock enable
// assumes a free-running clk; slow asks for random stalls
`timescale 1ns/1ps
`default_nettype none
module isu_stall_model (
  input wire logic clk,
  input wire logic slow,
  output logic clkEn
);
  int s = 7;
  // about one edge in four is stalled while slow is high
  always @(posedge clk) clkEn <= !slow || (($random(s) & 3) != 0);
endmodule : isu_stall_model
`default_nettype wire

// ==== sim/isu_int_shift_subtract_unit_tb.sv ====
// self-checking bench for the shift and subtract slice
// assumes isu_pkg and the stall model are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module isu_int_shift_subtract_unit_tb;
  import isu_pkg::*;
  logic clk = 0, resetn = 0, opValid = 0, slow = 0, clkEn, tk = 0;
  isu_op_e opSel = ISU_SRA_REG;
  logic [31:0] a = 0, b = 0, result;
  logic [4:0] f = 0;
  logic destWrite, overflow;
  logic [33:0] q[$], e; // expected {result, write, overflow}
  int failures = 0, checks = 0, seed = 63759;
  initial forever #4 clk = ~clk;
  isu_stall_model u_isu_stall_model (.clk(clk), .slow(slow), .clkEn(clkEn));
  isu_int_shift_subtract_unit u_isu_int_shift_subtract_unit (.clk(clk), .resetn(resetn),
    .clkEn(clkEn), .opValid(opValid), .opSel(opSel), .firstSource(a), .secondSource(b),
    .shiftAmountField(f), .result(result), .destWrite(destWrite), .overflow(overflow));
  // expected outcome of one operation
  function automatic logic [33:0] ex(int o, logic [31:0] x, y, logic [4:0] n);
    logic [32:0] d;
    d = {x[31], x} - {y[31], y};
    case (o)
      0: ex = {$signed(y) >>> x[4:0], 2'b10};
      1: ex = {y >> n, 2'b10};
      2: ex = {y >> x[4:0], 2'b10};
      3: ex = {d[31:0], d[32] == d[31], d[32] != d[31]};
      4: ex = {x - y, 2'b10};
      default: ex = '0;
    endcase
  endfunction : ex
  // drive one request and hold it until an enabled edge takes it
  task automatic op(int o, logic [31:0] x, y, logic [4:0] n);
    opValid <= 1'b1;
    opSel <= isu_op_e'(o);
    a <= x;
    b <= y;
    f <= n;
    q.push_back(ex(o, x, y, n));
    do @(posedge clk); while (!clkEn);
  endtask : op
  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  // results show right after the edge that took the request
  always @(posedge clk) tk <= resetn && clkEn && opValid;
  always @(negedge clk)
  begin
    if (tk)
    begin
      e = q.pop_front();
      `CHK("result", e[33:2], result)
      `CHK("flags", e[1:0], {destWrite, overflow})
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    `CHK("reset", 34'h0, {result, destWrite, overflow})
    op(3, 32'h80000000, 32'h1, 0);
    op(3, 32'h7fffffff, 32'hffffffff, 0);
    op(3, 32'hffffffff, 32'h7fffffff, 0);
    op(4, 32'h80000000, 32'h1, 0);
    op(0, 32'hffffffe4, 32'h80000010, 0);
    op(0, 32'h1f, 32'h80000000, 3);
    op(1, 32'hffffffff, 32'h80000000, 31);
    op(2, 32'hffffffff, 32'hffffffff, 7);
    for (int i = 5; i < 8; i++)
      op(i, 32'h5, 32'h9, 1);
    slow <= 1'b1;
    repeat (300)
      op({$random(seed)} % 5, $random(seed), $random(seed), 5'($random(seed)));
    opValid <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("queue", 0, q.size())
    final_report;
  end
  // watchdog well past the expected run length
  initial
  begin
    #40000;
    failures++;
    final_report;
  end
endmodule : isu_int_shift_subtract_unit_tb
`default_nettype wire
